// file: rtl/emws_pkg.sv
`default_nettype none

// Shared constants and types for the external memory write and ready sequencer.
package emws_pkg;

   // Clock rates; the interface timing clock is a fixed division of the system clock.
   localparam int SYS_CLK_PERIOD_NS = 50;
   localparam int TIM_CLK_PERIOD_NS = 100;
   localparam int TIM_DIV           = TIM_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;
   localparam int TIM_CNT_W         = (TIM_DIV > 2) ? $clog2(TIM_DIV) : 1;

   // External bus widths and the width of the cycle counters.
   localparam int ADDR_W  = 19;
   localparam int DATA_W  = 16;
   localparam int CNT_W   = 8;
   localparam int LEAD_W  = 2;
   localparam int ACT_W   = 3;
   localparam int TRAIL_W = 2;

   // Asynchronous ready is sampled this many timing cycles ahead of synchronous ready.
   localparam logic [CNT_W-1:0] READY_ASYNC_ADVANCE = 8'h02;

   // Register bus geometry and byte offsets.
   localparam int AV_AW = 5;
   localparam int AV_DW = 32;
   localparam logic [AV_AW-1:0] REG_CONFIG  = 5'h00;
   localparam logic [AV_AW-1:0] REG_ADDRESS = 5'h04;
   localparam logic [AV_AW-1:0] REG_WDATA   = 5'h08;
   localparam logic [AV_AW-1:0] REG_COMMAND = 5'h0c;
   localparam logic [AV_AW-1:0] REG_STATUS  = 5'h10;
   localparam logic [AV_AW-1:0] REG_RDATA   = 5'h14;

   // Bit positions in the command and status registers.
   localparam int CMD_START_BIT  = 0;
   localparam int CMD_WRITE_BIT  = 1;
   localparam int STAT_BUSY_BIT  = 0;
   localparam int STAT_PEND_BIT  = 1;
   localparam int STAT_READY_BIT = 2;

   // Zone timing configuration, packed high bit first as it sits in the config register.
   typedef struct packed {
      logic               bus_clock_half;
      logic               timing_doubler;
      logic               ready_sample_mode;
      logic               ready_sense_enable;
      logic [TRAIL_W-1:0] write_trail_cycles;
      logic [ACT_W-1:0]   write_active_cycles;
      logic [LEAD_W-1:0]  write_lead_cycles;
      logic [TRAIL_W-1:0] read_trail_cycles;
      logic [ACT_W-1:0]   read_active_cycles;
      logic [LEAD_W-1:0]  read_lead_cycles;
   } emws_cfg_s;

   localparam emws_cfg_s CFG_RESET = '{
      bus_clock_half: 1'b0, timing_doubler: 1'b0, ready_sample_mode: 1'b0,
      ready_sense_enable: 1'b0, write_trail_cycles: 2'h3, write_active_cycles: 3'h7,
      write_lead_cycles: 2'h3, read_trail_cycles: 2'h3, read_active_cycles: 3'h7,
      read_lead_cycles: 2'h3};

   typedef enum logic [2:0] {SEQ_IDLE, SEQ_ALIGN, SEQ_LEAD, SEQ_ACTIVE, SEQ_TRAIL, SEQ_RELEASE}
      emws_seq_e;

   // External pin group, every field a flip-flop.
   typedef struct packed {
      logic              zone_select_n;
      logic              read_strobe_n;
      logic              write_strobe_n;
      logic              read_not_write;
      logic [ADDR_W-1:0] ext_address_bus;
      logic [DATA_W-1:0] ext_data_out;
      logic              ext_data_oe;
   } emws_pins_s;

   localparam emws_pins_s PINS_IDLE = '{
      zone_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1, read_not_write: 1'b1,
      ext_address_bus: '0, ext_data_out: '0, ext_data_oe: 1'b0};

   // Whole state of the timing clock generator.
   typedef struct packed {
      logic [TIM_CNT_W-1:0] cnt;
      logic                 tick;
      logic                 phase;
      logic                 rise_next;
      logic                 clk_out;
   } emws_tick_s;

endpackage

`default_nettype wire

// file: rtl/emws_sync.sv
`default_nettype none

// Two flip-flop synchroniser for pins that arrive from outside the system clock.
module emws_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } emws_sync_s;

   emws_sync_s st;
   emws_sync_s next_st;

   // The first stage feeds only the second stage.
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   // Both stages clear on reset.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule

`default_nettype wire

// file: rtl/emws_tick_gen.sv
`default_nettype none

// Interface timing clock as a tick, and the output bus clock at that rate or half of it.
module emws_tick_gen
   import emws_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   input  wire logic bus_clock_half,
   output logic      tick,
   output logic      rise_next,
   output logic      bus_clock_out
);
   emws_tick_s st;
   emws_tick_s next_st;

   // The tick marks the last system cycle of a timing cycle; state changes on it land on
   // the next timing clock rising edge. In half mode an even count of timing cycles lands
   // on a rising edge of the bus clock, an odd count on a falling one.
   always_comb begin
      next_st = st;
      next_st.cnt = (st.cnt == TIM_CNT_W'(TIM_DIV - 1)) ? '0 : st.cnt + TIM_CNT_W'(1);
      next_st.tick = (next_st.cnt == TIM_CNT_W'(TIM_DIV - 1));
      if (!bus_clock_half) begin
         next_st.phase = 1'b0;
      end else if (st.tick) begin
         next_st.phase = ~st.phase;
      end
      next_st.rise_next = next_st.tick && (!bus_clock_half || next_st.phase);
      next_st.clk_out = bus_clock_half ? !next_st.phase
                                       : (next_st.cnt < TIM_CNT_W'(TIM_DIV / 2));
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick          = st.tick;
   assign rise_next     = st.rise_next;
   assign bus_clock_out = st.clk_out;
endmodule

`default_nettype wire

// file: rtl/emws_sequencer.sv
// Operation
// - Start every access on bus clock rising edge.
// - Alignment cycles keep all strobes inactive.
// - Address bus holds last address between accesses.
// - Ready sense off ignores the ready input.
// - Synchronous first sample after lead plus active.
// - Synchronous: high completes, low resamples each cycle.
// - Asynchronous first sample two cycles earlier.
// - Asynchronous: high ends, low resamples each cycle.
// - Synchronous sample n at lead plus active plus n-1.
// - Drive data from write strobe until direction high.
// - Hold write data through the write trail.
// - Count periods and move strobes on timing clock.
// - Half rate: even counts rise, odd fall.
`default_nettype none

module emws_sequencer
   import emws_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic [AV_AW-1:0]  avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [AV_DW-1:0]  avs_writedata,
   output logic      [AV_DW-1:0]  avs_readdata,
   output logic                   avs_waitrequest,
   output logic                   bus_clock_out,
   output logic                   zone_select_n,
   output logic                   read_strobe_n,
   output logic                   write_strobe_n,
   output logic                   read_not_write,
   output logic      [ADDR_W-1:0] ext_address_bus,
   output logic      [DATA_W-1:0] ext_data_out,
   output logic                   ext_data_oe,
   input  wire logic [DATA_W-1:0] ext_data_in,
   input  wire logic              ext_ready_in
);

   // Whole state of the sequencer and its register file.
   typedef struct packed {
      emws_seq_e         state;
      emws_cfg_s         cfg;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic              cmd_pend;
      logic              cmd_write;
      logic [CNT_W-1:0]  elapsed;
      logic [CNT_W-1:0]  trail_cnt;
      logic [CNT_W-1:0]  end_at;
      logic              ready_ok;
      emws_pins_s        pins;
      logic [AV_DW-1:0]  readdata;
      logic              waitrequest;
   } emws_seq_s;

   localparam emws_seq_s SEQ_RESET = '{
      state: SEQ_IDLE, cfg: CFG_RESET, address: '0, wdata: '0, rdata: '0,
      cmd_pend: 1'b0, cmd_write: 1'b0, elapsed: '0, trail_cnt: '0, end_at: '0,
      ready_ok: 1'b0, pins: PINS_IDLE, readdata: '0, waitrequest: 1'b1};

   emws_seq_s st;
   emws_seq_s next_st;

   logic              tick;
   logic              rise_next;
   logic              bus_clk_q;
   logic              ready_s;
   logic [DATA_W-1:0] data_s;

   // Bus clock and timing tick; the half rate setting comes straight from the config.
   emws_tick_gen u_tick (
      .sys_clk        (sys_clk),
      .sys_rst        (sys_rst),
      .bus_clock_half (st.cfg.bus_clock_half),
      .tick           (tick),
      .rise_next      (rise_next),
      .bus_clock_out  (bus_clk_q)
   );

   // Ready and read data are asynchronous to the system clock, so both pass two stages.
   emws_sync #(
      .W (DATA_W + 1)
   ) u_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .d       ({ext_ready_in, ext_data_in}),
      .q       ({ready_s, data_s})
   );

   // Period lengths for the access in flight; the doubler makes every period twice as long.
   logic [CNT_W-1:0] lead_n;
   logic [CNT_W-1:0] act_n;
   logic [CNT_W-1:0] trail_n;
   logic [CNT_W-1:0] hold_n;
   logic [CNT_W-1:0] first_pt;
   logic [CNT_W-1:0] offset_n;
   logic [CNT_W-1:0] e1;
   logic [CNT_W-1:0] end_now;
   logic             busy;
   logic             in_access;
   logic             sample_now;
   logic             ready_hit;
   logic             ready_done;
   logic             active_over;
   logic             acc_wr;

   assign lead_n  = CNT_W'(st.cmd_write ? st.cfg.write_lead_cycles
                                        : st.cfg.read_lead_cycles) << st.cfg.timing_doubler;
   assign act_n   = CNT_W'(st.cmd_write ? st.cfg.write_active_cycles
                                        : st.cfg.read_active_cycles) << st.cfg.timing_doubler;
   assign trail_n = CNT_W'(st.cmd_write ? st.cfg.write_trail_cycles
                                        : st.cfg.read_trail_cycles) << st.cfg.timing_doubler;
   assign hold_n  = lead_n + act_n;

   // First sample point: lead plus active, or two cycles sooner in asynchronous mode.
   assign first_pt = !st.cfg.ready_sample_mode ? hold_n
                   : (hold_n > READY_ASYNC_ADVANCE) ? hold_n - READY_ASYNC_ADVANCE
                   : '0;
   // A high asynchronous sample still lets the access run to its programmed end.
   assign offset_n = st.cfg.ready_sample_mode ? READY_ASYNC_ADVANCE : '0;

   // Elapsed timing cycles saturate so a long ready stall cannot wrap the sample window.
   assign e1 = (&st.elapsed) ? st.elapsed : st.elapsed + CNT_W'(1);

   assign busy      = (st.state != SEQ_IDLE) || st.cmd_pend;
   assign in_access = (st.state == SEQ_LEAD) || (st.state == SEQ_ACTIVE);

   // Ready is only looked at when sensing is on; otherwise the counts alone decide.
   // The partner is relied on to hold ready low while it needs more time.
   assign sample_now = st.cfg.ready_sense_enable && !st.ready_ok && in_access
                       && (e1 >= first_pt);
   assign ready_hit  = sample_now && ready_s;
   assign end_now    = ready_hit ? e1 + offset_n : st.end_at;
   assign ready_done = !st.cfg.ready_sense_enable || st.ready_ok || ready_hit;
   // A low sample blocks the end and the check repeats on the next tick.
   assign active_over = (e1 >= hold_n) && ready_done && (e1 >= end_now);

   assign acc_wr = avs_write && !st.waitrequest;

   // Register bus and sequencer next state.
   always_comb begin
      next_st = st;

      // One wait state for every request: waitrequest drops for the cycle after it is seen.
      next_st.waitrequest = !((avs_read || avs_write) && st.waitrequest);
      if (avs_read && st.waitrequest) begin
         unique case (avs_address)
            REG_CONFIG:  next_st.readdata = AV_DW'(st.cfg);
            REG_ADDRESS: next_st.readdata = AV_DW'(st.address);
            REG_WDATA:   next_st.readdata = AV_DW'(st.wdata);
            REG_RDATA:   next_st.readdata = AV_DW'(st.rdata);
            REG_STATUS: begin
               next_st.readdata = '0;
               next_st.readdata[STAT_BUSY_BIT]  = busy;
               next_st.readdata[STAT_PEND_BIT]  = st.cmd_pend;
               next_st.readdata[STAT_READY_BIT] = ready_s;
            end
            default:     next_st.readdata = '0;
         endcase
      end

      // Setup registers are frozen while an access is pending or running.
      if (acc_wr && !busy) begin
         unique case (avs_address)
            REG_CONFIG:  next_st.cfg = emws_cfg_s'(avs_writedata[$bits(emws_cfg_s)-1:0]);
            REG_ADDRESS: next_st.address = avs_writedata[ADDR_W-1:0];
            REG_WDATA:   next_st.wdata = avs_writedata[DATA_W-1:0];
            REG_COMMAND: begin
               next_st.cmd_pend  = avs_writedata[CMD_START_BIT];
               next_st.cmd_write = avs_writedata[CMD_WRITE_BIT];
            end
            default: ;
         endcase
      end

      // Write data is released one system cycle after direction has gone back high.
      if (st.state == SEQ_RELEASE) begin
         next_st.pins.ext_data_oe = 1'b0;
         next_st.state = SEQ_IDLE;
      end

      // Everything else moves only on timing clock ticks.
      if (tick) begin
         unique case (st.state)
            SEQ_IDLE, SEQ_ALIGN: begin
               if (st.cmd_pend && rise_next) begin
                  // Lead begins on the tick that precedes a bus clock rising edge.
                  next_st.state = SEQ_LEAD;
                  next_st.cmd_pend = 1'b0;
                  next_st.elapsed = '0;
                  next_st.end_at = '0;
                  next_st.ready_ok = 1'b0;
                  next_st.pins.zone_select_n = 1'b0;
                  next_st.pins.read_not_write = !st.cmd_write;
                  next_st.pins.ext_address_bus = st.address;
                  next_st.pins.ext_data_out = st.wdata;
               end else if (st.cmd_pend) begin
                  // Alignment cycle: strobes stay inactive and the address is untouched.
                  next_st.state = SEQ_ALIGN;
               end
            end
            SEQ_LEAD, SEQ_ACTIVE: begin
               next_st.elapsed = e1;
               if (ready_hit) begin
                  next_st.ready_ok = 1'b1;
                  next_st.end_at = end_now;
               end
               if (active_over) begin
                  next_st.pins.read_strobe_n = 1'b1;
                  next_st.pins.write_strobe_n = 1'b1;
                  if (!st.cmd_write) begin
                     next_st.rdata = data_s;
                  end
                  // Data stays driven and valid through the trail after the strobe rises.
                  if (trail_n == '0) begin
                     next_st.pins.zone_select_n = 1'b1;
                     next_st.pins.read_not_write = 1'b1;
                     next_st.state = st.cmd_write ? SEQ_RELEASE : SEQ_IDLE;
                  end else begin
                     next_st.state = SEQ_TRAIL;
                     next_st.trail_cnt = '0;
                  end
               end else if (e1 >= lead_n) begin
                  next_st.state = SEQ_ACTIVE;
                  next_st.pins.read_strobe_n = st.cmd_write;
                  next_st.pins.write_strobe_n = !st.cmd_write;
                  // The data drivers switch on together with the write strobe.
                  if (st.cmd_write) begin
                     next_st.pins.ext_data_oe = 1'b1;
                  end
               end
            end
            SEQ_TRAIL: begin
               next_st.trail_cnt = st.trail_cnt + CNT_W'(1);
               if (st.trail_cnt + CNT_W'(1) >= trail_n) begin
                  next_st.pins.zone_select_n = 1'b1;
                  next_st.pins.read_not_write = 1'b1;
                  next_st.state = st.cmd_write ? SEQ_RELEASE : SEQ_IDLE;
               end
            end
            SEQ_RELEASE: ;
         endcase
      end
   end

   // Single register stage for the whole block.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         st <= SEQ_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from flip-flops; the address is only loaded at an access start.
   assign avs_readdata    = st.readdata;
   assign avs_waitrequest = st.waitrequest;
   assign bus_clock_out   = bus_clk_q;
   assign zone_select_n   = st.pins.zone_select_n;
   assign read_strobe_n   = st.pins.read_strobe_n;
   assign write_strobe_n  = st.pins.write_strobe_n;
   assign read_not_write  = st.pins.read_not_write;
   assign ext_address_bus = st.pins.ext_address_bus;
   assign ext_data_out    = st.pins.ext_data_out;
   assign ext_data_oe     = st.pins.ext_data_oe;
endmodule

`default_nettype wire

// file: verification/emws_checker.sv
`default_nettype none

// Pin-level checks on the sequencer; it watches the top module's ports only.
module emws_checker
   import emws_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              sys_rst,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic              avs_waitrequest,
   input wire logic              bus_clock_out,
   input wire logic              zone_select_n,
   input wire logic              read_strobe_n,
   input wire logic              write_strobe_n,
   input wire logic              read_not_write,
   input wire logic [ADDR_W-1:0] ext_address_bus,
   input wire logic [DATA_W-1:0] ext_data_out,
   input wire logic              ext_data_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // External pin sequencing, judged only at system clock edges.
   chk_strobes_idle: assert property (zone_select_n |-> read_strobe_n && write_strobe_n)
      else $error("strobe active outside a selected access");
   chk_addr_hold: assert property (zone_select_n |-> $stable(ext_address_bus))
      else $error("address moved between accesses");
   chk_start_rise: assert property ($fell(zone_select_n) |-> $rose(bus_clock_out))
      else $error("access did not start on a rising bus clock");
   chk_clk_align: assert property (
      $changed({zone_select_n, read_strobe_n, write_strobe_n}) |-> $changed(bus_clock_out))
      else $error("strobe moved off a timing cycle boundary");
   chk_oe_with_we: assert property ($fell(write_strobe_n) |-> $rose(ext_data_oe))
      else $error("data drive did not start with the write strobe");
   chk_oe_release: assert property (
      $rose(read_not_write) |-> ext_data_oe ##1 !ext_data_oe)
      else $error("data bus released at the wrong time");
   chk_trail_data: assert property (
      !read_not_write && ext_data_oe |=> ext_data_oe && $stable(ext_data_out))
      else $error("write data changed before direction returned high");

   // Register bus answers after exactly one wait cycle, for one cycle.
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest)
      else $error("register bus answer late");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("register bus answer held too long");
endmodule

`default_nettype wire

// file: verification/emws_mem_model.sv
`default_nettype none

// Parallel memory on the far side: small word store and a delayed ready.
module emws_mem_model
   import emws_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              zone_select_n,
   input  wire logic              read_strobe_n,
   input  wire logic              write_strobe_n,
   input  wire logic              read_not_write,
   input  wire logic [ADDR_W-1:0] ext_address_bus,
   input  wire logic [DATA_W-1:0] ext_data_out,
   input  wire logic              ext_data_oe,
   input  wire logic [7:0]        ready_delay,
   output logic      [DATA_W-1:0] ext_data_in,
   output logic                   ext_ready_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [DATA_W-1:0] mem [16];
   logic [DATA_W-1:0] mdl_q   = 16'h0000;
   logic [DATA_W-1:0] last_wr = 16'h0000;
   logic [7:0]        cnt     = 8'h00;

   // The wire carries the device's data while it drives, else ours.
   assign ext_data_in = ext_data_oe ? ext_data_out : mdl_q;

   // Ready stays low for ready_delay cycles of a selected access, so it can stretch it.
   always @(posedge sys_clk) begin
      cnt <= zone_select_n ? 8'h00 : cnt + 8'h01;
      ext_ready_in <= !zone_select_n && (cnt + 8'h01 >= ready_delay);
      if (!write_strobe_n && ext_data_oe) begin
         mem[ext_address_bus[3:0]] <= ext_data_out;
         last_wr <= ext_data_out;
      end
      // Outside a read the line floats, so show a changing pattern, not the last word.
      if (!read_strobe_n && read_not_write) begin
         mdl_q <= mem[ext_address_bus[3:0]];
      end else begin
         mdl_q <= ~mdl_q;
      end
   end
endmodule

`default_nettype wire

// file: verification/emws_sequencer_bench.sv
`default_nettype none

// Register-bus driven bench that times each external access at the pins.
module emws_sequencer_bench
   import emws_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [3:0]        mode;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [7:0]        k;
      logic [2:0]        w;
   } emws_case_s;

   logic              sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, bus_clock_out;
   logic              zone_select_n, read_strobe_n, write_strobe_n, read_not_write;
   logic              ext_data_oe, ext_ready_in, pz, ps, st, c_zl, c_zh, c_sl, c_sh;
   logic [AV_AW-1:0]  avs_address;
   logic [AV_DW-1:0]  avs_writedata, avs_readdata, d;
   logic [ADDR_W-1:0] ext_address_bus;
   logic [DATA_W-1:0] ext_data_out, ext_data_in;
   logic [7:0]        ready_delay;
   int                mismatches, checks_done, cyc, t_zl, t_zh, t_sl, t_sh;
   emws_case_s        cases [7];

   emws_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_clock_out(bus_clock_out), .zone_select_n(zone_select_n),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .read_not_write(read_not_write), .ext_address_bus(ext_address_bus),
      .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
      .ext_ready_in(ext_ready_in));

   emws_mem_model mem (.sys_clk(sys_clk), .zone_select_n(zone_select_n),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .read_not_write(read_not_write), .ext_address_bus(ext_address_bus),
      .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ready_delay(ready_delay),
      .ext_data_in(ext_data_in), .ext_ready_in(ext_ready_in));

   // 20 MHz system clock.
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Time stamps of select and strobe edges, with the bus clock level at each.
   assign st = read_strobe_n & write_strobe_n;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      pz <= zone_select_n;
      ps <= st;
      if (pz && !zone_select_n) {t_zl, c_zl} <= {cyc, bus_clock_out};
      if (!pz && zone_select_n) {t_zh, c_zh} <= {cyc, bus_clock_out};
      if (ps && !st) {t_sl, c_sl} <= {cyc, bus_clock_out};
      if (!ps && st) {t_sh, c_sh} <= {cyc, bus_clock_out};
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One register transfer; the request stands until waitrequest is sampled low.
   task automatic av_xfer(input logic wr, input logic [AV_AW-1:0] a,
                          input logic [AV_DW-1:0] wd, output logic [AV_DW-1:0] rd);
      int n;
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      chk("waitrequest", 32'h0, 32'(avs_waitrequest));
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask

   // Bus clock level expected n timing cycles into an access.
   function automatic logic clk_at(input logic half, input int n);
      return half ? ~n[0] : 1'b1;
   endfunction

   // Program timing, start one access, wait for idle, then time the pins.
   task automatic run_case(input emws_case_s c);
      emws_cfg_s cf;
      int        m, ac;
      cf = '{c.mode[3], c.mode[2], c.mode[1], c.mode[0], 2'h1, 3'h1, 2'h1, 2'h1, 3'h3, 2'h1};
      m = c.mode[2] ? 2 : 1;
      ac = m * ((c.wr ? 1 : 3) + c.w);
      ready_delay <= c.k;
      av_xfer(1'b1, REG_CONFIG, AV_DW'(cf), d);
      av_xfer(1'b1, REG_ADDRESS, AV_DW'(c.addr), d);
      av_xfer(1'b1, REG_WDATA, AV_DW'(c.data), d);
      av_xfer(1'b1, REG_COMMAND, {30'h0, c.wr, 1'b1}, d);
      // The last answer may be stale and idle, so poll at least once.
      d = '1;
      for (int i = 0; i < 40 && d[STAT_BUSY_BIT] !== 1'b0; i++) av_xfer(1'b0, REG_STATUS, '0, d);
      chk("busy clears", 32'h0, 32'(d[STAT_BUSY_BIT]));
      chk("lead", 32'(2 * m), 32'(t_sl - t_zl));
      chk("active", 32'(2 * ac), 32'(t_sh - t_sl));
      chk("trail", 32'(2 * m), 32'(t_zh - t_sh));
      chk("clk at start", 32'h1, 32'(c_zl));
      chk("clk strobe on", 32'(clk_at(c.mode[3], m)), 32'(c_sl));
      chk("clk strobe off", 32'(clk_at(c.mode[3], m + ac)), 32'(c_sh));
      chk("clk at end", 32'(clk_at(c.mode[3], 2 * m + ac)), 32'(c_zh));
      chk("address held", 32'(c.addr), 32'(ext_address_bus));
      if (c.wr) begin
         chk("written word", 32'(c.data), 32'(mem.last_wr));
      end else begin
         av_xfer(1'b0, REG_RDATA, '0, d);
         chk("read word", 32'(c.data), d);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // The whole run is a few hundred cycles; this limit only catches a hang.
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      end_of_test();
   end

   // Mode bits are bus clock half, doubler, ready mode, ready sense.
   initial begin
      {sys_rst, pz, ps} = 3'b111;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {cyc, t_zl, t_zh, t_sl, t_sh, mismatches, checks_done} = '0;
      ready_delay = 8'hff;
      cases = '{'{4'h0, 1'b1, 19'h5a5a5, 16'hc3a5, 8'hff, 3'h0},
                '{4'h0, 1'b0, 19'h5a5a5, 16'hc3a5, 8'hff, 3'h0},
                '{4'h1, 1'b0, 19'h5a5a5, 16'hc3a5, 8'h09, 3'h2},
                '{4'h3, 1'b0, 19'h5a5a5, 16'hc3a5, 8'h05, 3'h2},
                '{4'h8, 1'b1, 19'h00123, 16'h7e81, 8'hff, 3'h0},
                '{4'h4, 1'b1, 19'h40001, 16'h0ff0, 8'hff, 3'h0},
                '{4'h1, 1'b1, 19'h40001, 16'h0ff0, 8'h00, 3'h0}};
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      chk("idle select", 32'h1, 32'(zone_select_n));
      av_xfer(1'b0, REG_CONFIG, '0, d);
      chk("config reset", 32'h0000_3fff, d);
      av_xfer(1'b0, REG_STATUS, '0, d);
      chk("status reset", 32'h0, d);
      av_xfer(1'b1, 5'h18, 32'hffff_ffff, d);
      av_xfer(1'b0, 5'h18, '0, d);
      chk("unmapped read", 32'h0, d);
      foreach (cases[i]) run_case(cases[i]);
      end_of_test();
   end
endmodule

bind emws_sequencer emws_checker u_chk (.sys_clk, .sys_rst, .avs_read, .avs_write,
   .avs_waitrequest, .bus_clock_out, .zone_select_n, .read_strobe_n, .write_strobe_n,
   .read_not_write, .ext_address_bus, .ext_data_out, .ext_data_oe);

`default_nettype wire
